/* File: common/seq_pkg.sv */
`default_nettype none
package seq_pkg;
   // ==========================================
   // Command codes
   localparam logic [7:0] CMD_PG_ON = 8'h5E;
   localparam logic [7:0] CMD_PG_OFF = 8'h5F;
   localparam logic [7:0] CMD_TON_DLY = 8'h60;
   localparam logic [7:0] CMD_TON_RAMP = 8'h61;
   localparam logic [7:0] CMD_TON_LIM = 8'h62;
   localparam logic [7:0] CMD_TON_RESP = 8'h63;
   localparam logic [7:0] CMD_TIME_UNIT = 8'hD2;
   // ==========================================
   // Reset values
   localparam logic [15:0] RST_PG_ON = 16'h0000;
   localparam logic [15:0] RST_PG_OFF = 16'h0000;
   localparam logic [15:0] RST_TON_DLY = 16'h0000;
   localparam logic [15:0] RST_TON_RAMP = 16'h0000;
   localparam logic [15:0] RST_TON_LIM = 16'h0000;
   localparam logic [7:0] RST_TON_RESP = 8'h00;
   localparam logic [15:0] RST_TIME_UNIT = 16'h0001;
   // ==========================================
   // Fault response byte fields
   localparam int RESP_MODE_HI = 7;
   localparam int RESP_MODE_LO = 6;
   localparam int RESP_RETRY_HI = 5;
   localparam int RESP_RETRY_LO = 3;
   localparam int RESP_DLY_HI = 2;
   localparam int RESP_DLY_LO = 0;
   localparam logic [1:0] MODE_IGNORE = 2'h0;
   localparam logic [1:0] MODE_CONTINUE = 2'h1;
   localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
   localparam logic [1:0] MODE_LATCH = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   // ==========================================
   // Types
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_DELAY = 3'h1,
      ST_RAMP = 3'h2,
      ST_ON = 3'h3,
      ST_HOLD = 3'h4,
      ST_WAIT = 3'h5,
      ST_LATCH = 3'h6
   } seq_state_e;

   typedef struct packed {
      logic [15:0] pg_on;
      logic [15:0] pg_off;
      logic [15:0] ton_dly;
      logic [15:0] ton_ramp;
      logic [15:0] ton_lim;
      logic [7:0] ton_resp;
      logic [15:0] time_unit;
   } cfg_s;

   typedef struct packed {
      cfg_s cfg;
      seq_state_e state;
      logic [2:0] ctrl_sync;
      logic ctrl_on;
      logic [15:0] tick;
      logic [23:0] ms_elapsed;
      logic [15:0] ton_ms;
      logic [2:0] attempts;
      logic ton_fault;
      logic pg_level;
      logic pg_status;
      logic exhausted;
      logic vout_enable;
      logic ramp_active;
      logic power_good;
      logic [15:0] rdata;
      logic ack;
   } seq_regs_s;
endpackage : seq_pkg
`default_nettype wire

/* File: hdl/output_sequencing_fault_retry.sv */
// Behaviour
// - Codes 101/110 allow five/six restarts, then latch.
// - Restart spacing is delay count times unit.
// - Code 111 retries until off or forced.
// - Delay field decodes as power of two.
// - Delay count sets continue time and spacing.
// - Time unit comes from register 0xD2.
// - Assert power good at assert threshold.
// - Negate power good below threshold, if enabled.
// - Set power good status below negate threshold.
// - Thresholds are 16-bit unsigned output-voltage values.
// - Wait turn-on delay before raising output.
// - Ramp output over programmed rise time.
// - Flag fault if undervoltage limit missed in time.
// - Zero timeout limit disables the check.
// - Response field selects ignore/continue/retry/latch.
// - Retry code 000 never restarts.
`timescale 1ns/1ps
`default_nettype none

module output_sequencing_fault_retry #(
   parameter int unsigned MS_CYCLES = seq_pkg::MS_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_cmd_valid,
   input wire logic i_cmd_write,
   input wire logic [7:0] i_cmd_code,
   input wire logic [15:0] i_cmd_wdata,
   output logic [15:0] o_cmd_rdata,
   output logic o_cmd_ack,
   input wire logic i_ctrl_pin,
   input wire logic i_operation_on,
   input wire logic i_clear_faults,
   input wire logic i_forced_fault,
   input wire logic i_pg_pin_enable,
   input wire logic [15:0] i_vout,
   input wire logic [15:0] i_vout_uv_limit,
   output logic o_vout_enable,
   output logic o_ramp_active,
   output logic o_power_good_output,
   output logic o_pg_status,
   output logic o_ton_fault,
   output logic o_retries_exhausted
);

   seq_pkg::seq_regs_s r;
   seq_pkg::seq_regs_s next_r;

   logic [1:0] resp_mode;
   logic [2:0] resp_retry;
   logic [2:0] resp_dly;
   logic [23:0] retry_ms;
   logic ms_pulse;
   logic enabled;
   logic turn_on;
   logic turn_off;
   logic below_uv;
   logic timeout;
   logic may_retry;

   // ==========================================
   // Decode of the fault response byte
   always_comb begin
      resp_mode = r.cfg.ton_resp[seq_pkg::RESP_MODE_HI:seq_pkg::RESP_MODE_LO];
      resp_retry = r.cfg.ton_resp[seq_pkg::RESP_RETRY_HI:seq_pkg::RESP_RETRY_LO];
      resp_dly = r.cfg.ton_resp[seq_pkg::RESP_DLY_HI:seq_pkg::RESP_DLY_LO];
      // Units per code are 1 << code; unit length is the 0xD2 value in ms
      retry_ms = {8'h00, r.cfg.time_unit} << resp_dly;
      ms_pulse = (r.tick == 16'(MS_CYCLES - 1));
      // Pin changes count only once the last two sync stages agree
      enabled = r.ctrl_on & i_operation_on;
      turn_on = enabled & (r.state == seq_pkg::ST_OFF);
      turn_off = ~enabled;
      below_uv = (i_vout < i_vout_uv_limit);
      timeout = (r.cfg.ton_lim != 16'h0000) & below_uv & (r.ton_ms >= r.cfg.ton_lim);
      // Bounded counts 1..6 stop at the field value, 111 never stops
      may_retry = (resp_retry == seq_pkg::RETRY_FOREVER) | (r.attempts < resp_retry);
   end

   // ==========================================
   // Next state
   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;

      // Command port: one word per write keeps every setting coherent
      if (i_cmd_valid) begin
         next_r.ack = 1'b1;
         next_r.rdata = 16'h0000;
         if (i_cmd_write) begin
            unique case (i_cmd_code)
               seq_pkg::CMD_PG_ON: next_r.cfg.pg_on = i_cmd_wdata;
               seq_pkg::CMD_PG_OFF: next_r.cfg.pg_off = i_cmd_wdata;
               seq_pkg::CMD_TON_DLY: next_r.cfg.ton_dly = i_cmd_wdata;
               seq_pkg::CMD_TON_RAMP: next_r.cfg.ton_ramp = i_cmd_wdata;
               seq_pkg::CMD_TON_LIM: next_r.cfg.ton_lim = i_cmd_wdata;
               seq_pkg::CMD_TON_RESP: next_r.cfg.ton_resp = i_cmd_wdata[7:0];
               seq_pkg::CMD_TIME_UNIT: next_r.cfg.time_unit = i_cmd_wdata;
               default: next_r.cfg = r.cfg;
            endcase
         end else begin
            unique case (i_cmd_code)
               seq_pkg::CMD_PG_ON: next_r.rdata = r.cfg.pg_on;
               seq_pkg::CMD_PG_OFF: next_r.rdata = r.cfg.pg_off;
               seq_pkg::CMD_TON_DLY: next_r.rdata = r.cfg.ton_dly;
               seq_pkg::CMD_TON_RAMP: next_r.rdata = r.cfg.ton_ramp;
               seq_pkg::CMD_TON_LIM: next_r.rdata = r.cfg.ton_lim;
               seq_pkg::CMD_TON_RESP: next_r.rdata = {8'h00, r.cfg.ton_resp};
               seq_pkg::CMD_TIME_UNIT: next_r.rdata = r.cfg.time_unit;
               default: next_r.rdata = 16'h0000;
            endcase
         end
      end

      // Control pin synchroniser
      next_r.ctrl_sync = {r.ctrl_sync[1:0], i_ctrl_pin};
      if (r.ctrl_sync[2] == r.ctrl_sync[1]) begin
         next_r.ctrl_on = r.ctrl_sync[2];
      end

      // Millisecond prescaler, restarted whenever a timed state begins
      next_r.tick = ms_pulse ? 16'h0000 : r.tick + 16'h0001;
      if (ms_pulse) begin
         next_r.ms_elapsed = r.ms_elapsed + 24'h000001;
      end

      // Turn-on timeout runs from the start of the ramp until the
      // output clears the undervoltage limit
      if ((r.state == seq_pkg::ST_RAMP) || (r.state == seq_pkg::ST_ON)) begin
         if (ms_pulse && below_uv && (r.ton_ms != 16'hFFFF)) begin
            next_r.ton_ms = r.ton_ms + 16'h0001;
         end
      end else begin
         next_r.ton_ms = 16'h0000;
      end

      unique case (r.state)
         seq_pkg::ST_OFF: begin
            if (turn_on) begin
               next_r.state = seq_pkg::ST_DELAY;
               next_r.ms_elapsed = 24'h000000;
               next_r.tick = 16'h0000;
            end
         end
         seq_pkg::ST_DELAY: begin
            if (r.ms_elapsed >= {8'h00, r.cfg.ton_dly}) begin
               next_r.state = seq_pkg::ST_RAMP;
               next_r.ms_elapsed = 24'h000000;
               next_r.tick = 16'h0000;
            end
         end
         seq_pkg::ST_RAMP: begin
            if (r.ms_elapsed >= {8'h00, r.cfg.ton_ramp}) begin
               next_r.state = seq_pkg::ST_ON;
            end
         end
         seq_pkg::ST_ON: begin
         end
         seq_pkg::ST_HOLD: begin
            // Keeps running for the delay, then acts only if still low
            if (r.ms_elapsed >= retry_ms) begin
               if (!below_uv) begin
                  next_r.state = seq_pkg::ST_ON;
               end else if (may_retry) begin
                  next_r.state = seq_pkg::ST_WAIT;
                  next_r.attempts = r.attempts + 3'h1;
                  next_r.ms_elapsed = 24'h000000;
                  next_r.tick = 16'h0000;
               end else begin
                  next_r.state = seq_pkg::ST_LATCH;
                  next_r.exhausted = 1'b1;
               end
            end
         end
         seq_pkg::ST_WAIT: begin
            if (r.ms_elapsed >= retry_ms) begin
               next_r.state = seq_pkg::ST_DELAY;
               next_r.ms_elapsed = 24'h000000;
               next_r.tick = 16'h0000;
            end
         end
         seq_pkg::ST_LATCH: begin
         end
         default: next_r.state = seq_pkg::ST_LATCH;
      endcase

      // Turn-on timeout and its response
      if (timeout && ((r.state == seq_pkg::ST_RAMP) || (r.state == seq_pkg::ST_ON))) begin
         next_r.ton_fault = 1'b1;
         next_r.ms_elapsed = 24'h000000;
         next_r.tick = 16'h0000;
         unique case (resp_mode)
            seq_pkg::MODE_IGNORE: next_r.ton_ms = 16'h0000;
            seq_pkg::MODE_CONTINUE: next_r.state = seq_pkg::ST_HOLD;
            seq_pkg::MODE_DISABLE_RETRY: begin
               if (may_retry) begin
                  next_r.state = seq_pkg::ST_WAIT;
                  next_r.attempts = r.attempts + 3'h1;
               end else begin
                  next_r.state = seq_pkg::ST_LATCH;
                  next_r.exhausted = 1'b1;
               end
            end
            seq_pkg::MODE_LATCH: next_r.state = seq_pkg::ST_LATCH;
         endcase
      end

      // Another fault shuts the unit down and ends any retry loop
      if (i_forced_fault && (r.state != seq_pkg::ST_OFF)) begin
         next_r.state = seq_pkg::ST_LATCH;
      end

      // A clear alone must not drop a healthy running output
      if (i_clear_faults) begin
         next_r.attempts = 3'h0;
         next_r.ton_fault = 1'b0;
         if (r.state == seq_pkg::ST_HOLD) begin
            next_r.state = seq_pkg::ST_ON;
            next_r.exhausted = 1'b0;
            next_r.ms_elapsed = 24'h000000;
         end
      end
      // Clearing a latch or wait, or an off command, resets the retry history
      if (turn_off || (i_clear_faults && ((r.state == seq_pkg::ST_LATCH) ||
                                          (r.state == seq_pkg::ST_WAIT)))) begin
         next_r.state = seq_pkg::ST_OFF;
         next_r.attempts = 3'h0;
         next_r.ms_elapsed = 24'h000000;
         next_r.ton_fault = 1'b0;
         next_r.exhausted = 1'b0;
      end

      // Power good with hysteresis between the two thresholds
      if ((r.state == seq_pkg::ST_ON) && (i_vout >= r.cfg.pg_on)) begin
         next_r.pg_level = 1'b1;
      end else if ((i_vout < r.cfg.pg_off) || !r.vout_enable) begin
         next_r.pg_level = 1'b0;
      end
      // Status flag: a new low reading wins over a clear in the same cycle
      if (i_clear_faults) begin
         next_r.pg_status = 1'b0;
      end
      if (r.vout_enable && (i_vout < r.cfg.pg_off)) begin
         next_r.pg_status = 1'b1;
      end
      // Same precedence for the turn-on fault flag
      if (timeout && (r.state == seq_pkg::ST_ON || r.state == seq_pkg::ST_RAMP)) begin
         next_r.ton_fault = 1'b1;
      end

      next_r.power_good = next_r.pg_level & i_pg_pin_enable;
      next_r.vout_enable = (next_r.state == seq_pkg::ST_RAMP) |
                           (next_r.state == seq_pkg::ST_ON) |
                           (next_r.state == seq_pkg::ST_HOLD);
      next_r.ramp_active = (next_r.state == seq_pkg::ST_RAMP);
   end

   // ==========================================
   // State register
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= '0;
         r.cfg.pg_on <= seq_pkg::RST_PG_ON;
         r.cfg.pg_off <= seq_pkg::RST_PG_OFF;
         r.cfg.ton_dly <= seq_pkg::RST_TON_DLY;
         r.cfg.ton_ramp <= seq_pkg::RST_TON_RAMP;
         r.cfg.ton_lim <= seq_pkg::RST_TON_LIM;
         r.cfg.ton_resp <= seq_pkg::RST_TON_RESP;
         r.cfg.time_unit <= seq_pkg::RST_TIME_UNIT;
         r.state <= seq_pkg::ST_OFF;
      end else begin
         r <= next_r;
      end
   end

   always_comb begin
      o_cmd_rdata = r.rdata;
      o_cmd_ack = r.ack;
      o_vout_enable = r.vout_enable;
      o_ramp_active = r.ramp_active;
      o_power_good_output = r.power_good;
      o_pg_status = r.pg_status;
      o_ton_fault = r.ton_fault;
      o_retries_exhausted = r.exhausted;
   end

endmodule // output_sequencing_fault_retry

`default_nettype wire

/* File: tb/vout_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none

module vout_stage_model (
   input wire logic i_core_clk,
   input wire logic i_enable,
   input wire logic i_healthy,
   output logic [15:0] o_vout
);
   // ==========================================
   // Power stage and output monitor
   initial o_vout = 16'h0000;
   always @(posedge i_core_clk) begin
      if (!i_enable) begin
         // Output discharges to ground once the stage is off
         o_vout <= 16'h0000;
      end else if (!i_healthy) begin
         o_vout <= 16'h0010;
      end else if (o_vout < 16'h0400) begin
         o_vout <= o_vout + 16'h0040;
      end
   end
endmodule // vout_stage_model

`default_nettype wire

/* File: tb/seq_props.sv */
`timescale 1ns/1ps
`default_nettype none

module seq_props (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_cmd_valid,
   input wire logic o_cmd_ack,
   input wire logic i_operation_on,
   input wire logic i_forced_fault,
   input wire logic i_pg_pin_enable,
   input wire logic [15:0] i_vout,
   input wire logic [15:0] i_vout_uv_limit,
   input wire logic o_vout_enable,
   input wire logic o_ramp_active,
   input wire logic o_power_good_output,
   input wire logic o_ton_fault,
   input wire logic o_retries_exhausted
);
   // ==========================================
   // Port relations
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);
   a_ack_one_cycle: assert property (o_cmd_ack == $past(i_cmd_valid))
      else $error("ack not one cycle after strobe");
   a_ramp_enables: assert property (o_ramp_active |-> o_vout_enable)
      else $error("ramp without output enable");
   a_enable_cause: assert property ($rose(o_vout_enable) |->
      $past(i_operation_on) && !$past(o_retries_exhausted))
      else $error("output enabled without cause");
   a_off_drops: assert property (!i_operation_on |-> ##[1:3] !o_vout_enable)
      else $error("output stays on after off");
   a_forced_off: assert property (i_forced_fault |-> ##[1:3] !o_vout_enable)
      else $error("output stays on after forced fault");
   a_exhausted_off: assert property (o_retries_exhausted |-> !o_vout_enable)
      else $error("output on after retries used up");
   a_fault_cause: assert property ($rose(o_ton_fault) |->
      $past(i_vout) < $past(i_vout_uv_limit))
      else $error("timeout fault with output above limit");
   a_pg_pin_gate: assert property ($rose(o_power_good_output) |->
      $past(i_pg_pin_enable) && $past(o_vout_enable))
      else $error("power good raised while not allowed");
   a_pg_pin_low: assert property (!i_pg_pin_enable |=> !o_power_good_output)
      else $error("power good shown while pin disabled");
   c_exhausted: cover property ($rose(o_retries_exhausted));
   c_pg_drop: cover property ($fell(o_power_good_output));
   c_fault_on: cover property ($rose(o_ton_fault) && o_vout_enable);
endmodule // seq_props

bind output_sequencing_fault_retry seq_props props (.i_core_clk, .i_sys_rst, .i_cmd_valid,
   .o_cmd_ack, .i_operation_on, .i_forced_fault, .i_pg_pin_enable, .i_vout, .i_vout_uv_limit,
   .o_vout_enable, .o_ramp_active, .o_power_good_output, .o_ton_fault, .o_retries_exhausted);

`default_nettype wire

/* File: tb/tb_output_sequencing_fault_retry.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_output_sequencing_fault_retry;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic valid = 1'b0;
   logic write = 1'b0;
   logic [7:0] code = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic ctrl = 1'b0;
   logic op = 1'b1;
   logic clr = 1'b0;
   logic forced = 1'b0;
   logic healthy = 1'b1;
   logic pgen = 1'b1;
   logic [15:0] rdata, vout;
   logic ack, ven, ramp, pg, pgst, tfault, exh;
   int n_fail = 0;
   int checked = 0;
   int n;
   logic [7:0] codes [8] = '{8'h5E, 8'h5F, 8'h60, 8'h61, 8'h62, 8'h63, 8'hD2, 8'h00};
   logic [15:0] cfgv [8] = '{16'h0300, 16'h0200, 16'h0003, 16'h0002, 16'h0000, 16'h0000,
      16'h0002, 16'h1234};

   always #20 clk = ~clk;

   // Millisecond prescaler cut to 10 cycles to keep the run short
   output_sequencing_fault_retry #(.MS_CYCLES(10)) dut (.i_core_clk(clk), .i_sys_rst(rst),
      .i_cmd_valid(valid), .i_cmd_write(write), .i_cmd_code(code), .i_cmd_wdata(wdata),
      .o_cmd_rdata(rdata), .o_cmd_ack(ack), .i_ctrl_pin(ctrl), .i_operation_on(op),
      .i_clear_faults(clr), .i_forced_fault(forced), .i_pg_pin_enable(pgen), .i_vout(vout),
      .i_vout_uv_limit(16'h0100), .o_vout_enable(ven), .o_ramp_active(ramp),
      .o_power_good_output(pg), .o_pg_status(pgst), .o_ton_fault(tfault),
      .o_retries_exhausted(exh));

   vout_stage_model model (.i_core_clk(clk), .i_enable(ven), .i_healthy(healthy), .o_vout(vout));

   // ==========================================
   // Checks and access tasks
   task automatic complete_run();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chkr(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      checked++;
      if (!(got >= lo && got <= hi) || $isunknown(got)) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   // Strobe stays up across back-to-back calls; the caller lowers it
   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
      valid = 1'b1;
      write = w;
      code = c;
      wdata = d;
      @(negedge clk);
      chkr(16'(ack), 16'h0001, 16'h0001);
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      cmd(1'b0, c, 16'h0000);
      chkr(rdata, exp, exp);
   endtask

   task automatic wt(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, s, v);
            complete_run();
         end
      end
   endtask

   task automatic start_run(input logic [7:0] resp);
      op = 1'b0;
      repeat (8) @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      chkr(16'(exh), 16'h0000, 16'h0000);
      cmd(1'b1, 8'h63, {8'h00, resp});
      valid = 1'b0;
      op = 1'b1;
   endtask

   task automatic fault_run(input logic [7:0] resp, input int lo, input int hi);
      logic prev;
      prev = 1'b0;
      start_run(resp);
      n = 0;
      repeat (1500) begin
         @(negedge clk);
         if (ven && !prev) n++;
         prev = ven;
      end
      chkr(16'(n), 16'(lo), 16'(hi));
   endtask

   // ==========================================
   // Main sequence
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) rd(codes[i], (i == 6) ? 16'h0001 : 16'h0000);
      for (int i = 0; i < 8; i++) cmd(1'b1, codes[i], cfgv[i]);
      for (int i = 0; i < 8; i++) rd(codes[i], (i == 7) ? 16'h0000 : cfgv[i]);
      valid = 1'b0;
      ctrl = 1'b1;
      wt(ven, 1'b1, 100);
      chkr(16'(n), 16'd22, 16'd46);
      wt(ramp, 1'b0, 100);
      chkr(16'(n), 16'd10, 16'd32);
      wt(pg, 1'b1, 60);
      pgen = 1'b0;
      repeat (2) @(negedge clk);
      chkr(16'(pg), 16'h0000, 16'h0000);
      pgen = 1'b1;
      // Status was set during the ramp; clear it while the output stays up
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      wt(pg, 1'b1, 4);
      chkr(16'(pgst), 16'h0000, 16'h0000);
      chkr(16'(ven), 16'h0001, 16'h0001);
      healthy = 1'b0;
      wt(pg, 1'b0, 20);
      chkr(16'(pgst), 16'h0001, 16'h0001);
      forced = 1'b1;
      repeat (4) @(negedge clk);
      forced = 1'b0;
      start_run(8'h80);
      repeat (150) @(negedge clk);
      chkr(16'({tfault, ven}), 16'h0001, 16'h0001);
      cmd(1'b1, 8'h60, 16'h0000);
      cmd(1'b1, 8'h62, 16'h0003);
      valid = 1'b0;
      fault_run(8'hC1, 1, 1);
      fault_run(8'h81, 1, 1);
      fault_run(8'hA9, 6, 6);
      chkr(16'(exh), 16'h0001, 16'h0001);
      fault_run(8'hB1, 7, 7);
      fault_run(8'hB9, 10, 40);
      for (int d = 0; d < 8; d++) begin
         start_run({5'b10111, 3'(d)});
         wt(ven, 1'b1, 300);
         wt(ven, 1'b0, 300);
         wt(ven, 1'b1, 3000);
         chkr(16'(n), 16'((20 << d) - 12), 16'((20 << d) + 22));
      end
      start_run(8'h42);
      wt(tfault, 1'b1, 300);
      wt(ven, 1'b0, 300);
      chkr(16'(n), 16'd68, 16'd92);
      start_run(8'h00);
      wt(tfault, 1'b1, 300);
      repeat (100) @(negedge clk);
      chkr(16'(ven), 16'h0001, 16'h0001);
      complete_run();
   end
endmodule // tb_output_sequencing_fault_retry

`default_nettype wire
